// ---- src/osc_clock_divider_pll_config.sv ----
// Oscillator control, clock divisor, PLL divisors and fast RC tuning registers with switch control
`timescale 1ns/10ps
`default_nettype none
module osc_clock_divider_pll_config
   import osc_ctrl_pkg::*;
(
   input  wire logic                          core_clk,        // Core clock, 100 MHz
   input  wire logic                          rst_n,           // Synchronous reset, active low
   input  wire logic                          por_n,           // Power-on reset, active low
   input  wire logic [osc_ctrl_pkg::ADDR_W-1:0] reg_addr,      // Register index
   input  wire logic [osc_ctrl_pkg::DATA_W-1:0] reg_wdata,     // Write data
   input  wire logic                          reg_wr,          // Write strobe
   input  wire logic                          reg_rd,          // Read strobe
   output logic      [osc_ctrl_pkg::DATA_W-1:0] reg_rdata,     // Read data, cycle after strobe
   input  wire logic                          switch_enable,   // Clock switching enabled by config
   input  wire logic [2:0]                    boot_source,     // Source chosen by config at power-on
   input  wire logic [1:0]                    primary_submode_config, // Primary submode pins
   input  wire logic                          fail_detect,     // Fail-safe monitor failure level
   input  wire logic                          pll_locked,      // PLL lock indication
   input  wire logic                          new_clk_ready,   // Requested oscillator is running
   input  wire logic                          new_clk_level,   // Level of the requested clock
   input  wire logic                          irq_any,         // Any interrupt taken
   output logic      [2:0]                    current_source_status, // Selected source
   output logic                               secondary_osc_run, // Secondary oscillator enable
   output logic      [2:0]                    request_source,  // Source to be started
   output logic                               clock_fail_trap, // One-cycle trap on failure while switching is enabled
   output logic      [1:0]                    primary_submode, // Primary submode in use
   output logic      [7:0]                    doze_divide,     // Processor/peripheral divide ratio
   output logic      [8:0]                    fast_rc_divide,  // Fast RC postscaler divide
   output logic      [3:0]                    pll_post_divide, // PLL output divide
   output logic      [5:0]                    pll_pre_divide,  // PLL input divide
   output logic      [9:0]                    pll_multiplier,  // PLL feedback multiplier
   output logic      [5:0]                    tuning_steps     // Signed tuning step count
);
   import osc_ctrl_pkg::*;

   function automatic logic is_pll(input logic [2:0] s);
      is_pll = (s == SRC_FRC_PLL) || (s == SRC_PRI_PLL);
   endfunction

   logic [2:0]  fail_sync;
   logic [2:0]  sync_in;
   logic        fail_s;
   logic        lock_s;
   logic        ready_s;
   logic        clk_s;

   // Asynchronous oscillator-side levels
   assign sync_in = {fail_detect, pll_locked, new_clk_ready};

   sync2 #(.W(3)) u_sync (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (sync_in),
      .q        (fail_sync)
   );

   sync2 #(.W(1)) u_sync_clk (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .d        (new_clk_level),
      .q        (clk_s)
   );

   assign fail_s  = fail_sync[2];
   assign lock_s  = fail_sync[1];
   assign ready_s = fail_sync[0];

   logic [2:0]  current_source_status_r,   current_source_status_nxt;
   logic [2:0]  new_source_select_r,   new_source_select_nxt;
   logic        cf_r,     cf_nxt;
   logic        sec_r,    sec_nxt;
   logic        swreq_r,  swreq_nxt;
   logic [15:0] cdiv_r,   cdiv_nxt;
   logic [8:0]  fbd_r,    fbd_nxt;
   logic [5:0]  tun_r,    tun_nxt;
   logic [1:0]  unl_r,    unl_nxt;
   logic        fail_d_r, fail_d_nxt;
   logic [1:0]  sub_r,    sub_nxt;
   logic        boot_r,   boot_nxt;
   logic        trap_r,   trap_nxt;
   logic [15:0] rdata_r,  rdata_nxt;
   sw_state_t   st_r,     st_nxt;
   logic        settle_start;
   logic        settle_done;
   logic        fail_rise;
   logic        wr_osc;
   logic        src_ok;

   settle_counter #(.COUNT(SETTLE_CYCLES)) u_settle (
      .core_clk (core_clk),
      .rst_n    (rst_n),
      .start    (settle_start),
      .clk_lvl  (clk_s),
      .done     (settle_done)
   );

   assign fail_rise    = fail_s && !fail_d_r;
   assign wr_osc       = reg_wr && reg_addr == OFS_OSC_CTRL && unl_r == 2'h2;
   assign settle_start = (st_r == SW_START);
   assign src_ok       = ready_s && (!is_pll(new_source_select_r) || lock_s);

   // Unlock sequence: two keys back to back; any other write re-locks
   always_comb begin
      unl_nxt = unl_r;
      if (reg_wr) begin
         if (reg_addr == OFS_UNLOCK && reg_wdata == UNLOCK_KEY1) begin
            unl_nxt = 2'h1;
         end else if (reg_addr == OFS_UNLOCK && reg_wdata == UNLOCK_KEY2 && unl_r == 2'h1) begin
            unl_nxt = 2'h2;
         end else begin
            unl_nxt = 2'h0;
         end
      end
   end

   // Oscillator control register and switch sequencer
   always_comb begin
      current_source_status_nxt   = current_source_status_r;
      new_source_select_nxt   = new_source_select_r;
      cf_nxt     = cf_r;
      sec_nxt    = sec_r;
      swreq_nxt  = swreq_r;
      st_nxt     = st_r;
      fail_d_nxt = fail_s;
      trap_nxt   = 1'b0;
      sub_nxt    = sub_r;
      boot_nxt   = 1'b0;
      if (boot_r) begin
         current_source_status_nxt = boot_source;
         new_source_select_nxt = boot_source;
         sub_nxt  = primary_submode_config;
      end
      if (wr_osc) begin
         new_source_select_nxt  = reg_wdata[NEW_SOURCE_SELECT_LSB +: 3];
         sec_nxt   = reg_wdata[SEC_EN_BIT];
         if (!reg_wdata[CF_BIT]) begin
            cf_nxt = 1'b0;
         end
         if (reg_wdata[SWREQ_BIT] && st_r == SW_IDLE) begin
            swreq_nxt = 1'b1;
         end
      end
      case (st_r)
         SW_IDLE: begin
            if (swreq_r) begin
               if (new_source_select_r == current_source_status_r) begin
                  swreq_nxt = 1'b0;
               end else begin
                  cf_nxt = 1'b0;
                  st_nxt = SW_START;
               end
            end
         end
         SW_START: begin
            if (src_ok) begin
               st_nxt = SW_SETTLE;
            end
         end
         SW_SETTLE: begin
            if (settle_done) begin
               st_nxt = SW_DONE;
            end
         end
         SW_DONE: begin
            current_source_status_nxt  = new_source_select_r;
            swreq_nxt = 1'b0;
            st_nxt    = SW_IDLE;
         end
         default: st_nxt = SW_IDLE;
      endcase
      if (fail_rise && switch_enable) begin
         cf_nxt   = 1'b1;
         trap_nxt = 1'b1;
         current_source_status_nxt = is_pll(current_source_status_r) ? SRC_FRC_PLL : SRC_FRC;
         st_nxt   = SW_IDLE;
         swreq_nxt = 1'b0;
      end
      if (!switch_enable) begin
         swreq_nxt = 1'b0;
         st_nxt    = SW_IDLE;
      end
   end

   // Divisor, feedback and tuning registers
   always_comb begin
      cdiv_nxt = cdiv_r;
      fbd_nxt  = fbd_r;
      tun_nxt  = tun_r;
      if (reg_wr) begin
         case (reg_addr)
            OFS_CLK_DIV:  cdiv_nxt = reg_wdata & CLK_DIV_MASK;
            OFS_PLL_FBD:  fbd_nxt  = reg_wdata[8:0];
            OFS_FRC_TUNE: tun_nxt  = reg_wdata[5:0];
            default:      cdiv_nxt = cdiv_r;
         endcase
      end
      if (irq_any && cdiv_nxt[ROI_BIT]) begin
         cdiv_nxt[REDUCTION_RATIO_ENABLE_BIT] = 1'b0;
      end
   end

   // Read data register
   always_comb begin
      rdata_nxt = 16'h0000;
      if (reg_rd) begin
         case (reg_addr)
            OFS_OSC_CTRL: begin
               rdata_nxt[CURRENT_SOURCE_STATUS_LSB +: 3] = current_source_status_r;
               rdata_nxt[NEW_SOURCE_SELECT_LSB +: 3] = new_source_select_r;
               rdata_nxt[LOCK_BIT]      = lock_s;
               rdata_nxt[CF_BIT]        = cf_r;
               rdata_nxt[SEC_EN_BIT]    = sec_r;
               rdata_nxt[SWREQ_BIT]     = swreq_r;
            end
            OFS_CLK_DIV:  rdata_nxt = cdiv_r;
            OFS_PLL_FBD:  rdata_nxt = {7'h00, fbd_r};
            OFS_FRC_TUNE: rdata_nxt = {10'h000, tun_r};
            OFS_SYS_STAT: rdata_nxt = {10'h000, st_r, unl_r};
            default:      rdata_nxt = 16'h0000;
         endcase
      end
   end

   // Configuration registers see only the power-on reset
   always_ff @(posedge core_clk) begin
      if (!por_n) begin
         current_source_status_r  <= SRC_FRC;
         new_source_select_r  <= SRC_FRC;
         cf_r    <= 1'b0;
         sec_r   <= 1'b0;
         swreq_r <= 1'b0;
         cdiv_r  <= CLK_DIV_RST;
         fbd_r   <= PLL_FBD_RST;
         tun_r   <= FRC_TUNE_RST;
         sub_r   <= 2'h0;
         boot_r  <= 1'b1;
      end else begin
         current_source_status_r  <= current_source_status_nxt;
         new_source_select_r  <= new_source_select_nxt;
         cf_r    <= cf_nxt;
         sec_r   <= sec_nxt;
         swreq_r <= swreq_nxt;
         cdiv_r  <= cdiv_nxt;
         fbd_r   <= fbd_nxt;
         tun_r   <= tun_nxt;
         sub_r   <= sub_nxt;
         boot_r  <= boot_nxt;
      end
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n || !por_n) begin
         st_r     <= SW_IDLE;
         unl_r    <= 2'h0;
         fail_d_r <= 1'b0;
         trap_r   <= 1'b0;
         rdata_r  <= 16'h0000;
      end else begin
         st_r     <= st_nxt;
         unl_r    <= unl_nxt;
         fail_d_r <= fail_d_nxt;
         trap_r   <= trap_nxt;
         rdata_r  <= rdata_nxt;
      end
   end

   // Decoded divide figures; the PLL itself forms Fin*M/(N1*N2)
   always_comb begin
      doze_divide = cdiv_r[REDUCTION_RATIO_ENABLE_BIT] ? 8'(8'h01 << cdiv_r[DOZE_LSB +: 3]) : 8'h01;
      fast_rc_divide = (cdiv_r[FAST_RC_POSTSCALER_LSB +: 3] == 3'h7) ? 9'h100 :
                       9'(9'h001 << cdiv_r[FAST_RC_POSTSCALER_LSB +: 3]);
      case (cdiv_r[POST_LSB +: 2])
         2'h0:    pll_post_divide = 4'h2;
         2'h1:    pll_post_divide = 4'h4;
         2'h3:    pll_post_divide = 4'h8;
         default: pll_post_divide = 4'h4;
      endcase
      pll_pre_divide = {1'b0, cdiv_r[PRE_LSB +: 5]} + 6'h02;
      pll_multiplier = {1'b0, fbd_r} + 10'h002;
   end

   assign reg_rdata             = rdata_r;
   assign current_source_status = current_source_status_r;
   assign secondary_osc_run     = sec_r;
   assign request_source        = new_source_select_r;
   assign clock_fail_trap       = trap_r;
   assign primary_submode       = sub_r;
   assign tuning_steps          = tun_r;
endmodule
`default_nettype wire

// ---- src/osc_ctrl_pkg.sv ----
// Package of register map, field layout, reset values and timing for the oscillator control block
package osc_ctrl_pkg;
   localparam int          ADDR_W          = 4;
   localparam int          DATA_W          = 16;
   localparam logic [3:0]  OFS_OSC_CTRL    = 4'h0;
   localparam logic [3:0]  OFS_CLK_DIV     = 4'h1;
   localparam logic [3:0]  OFS_PLL_FBD     = 4'h2;
   localparam logic [3:0]  OFS_FRC_TUNE    = 4'h3;
   localparam logic [3:0]  OFS_UNLOCK      = 4'h4;
   localparam logic [3:0]  OFS_SYS_STAT    = 4'h5;
   // Unlock keys, written in order to the unlock register
   localparam logic [15:0] UNLOCK_KEY1     = 16'h0046;
   localparam logic [15:0] UNLOCK_KEY2     = 16'h0057;
   // Oscillator control fields
   localparam int          CF_BIT          = 3;
   localparam int          SEC_EN_BIT      = 1;
   localparam int          SWREQ_BIT       = 0;
   localparam int          LOCK_BIT        = 5;
   localparam int          NEW_SOURCE_SELECT_LSB        = 8;
   localparam int          CURRENT_SOURCE_STATUS_LSB        = 12;
   // Clock divisor fields
   localparam int          ROI_BIT         = 15;
   localparam int          DOZE_LSB        = 12;
   localparam int          REDUCTION_RATIO_ENABLE_BIT       = 11;
   localparam int          FAST_RC_POSTSCALER_LSB      = 8;
   localparam int          POST_LSB        = 6;
   localparam int          PRE_LSB         = 0;
   localparam logic [15:0] CLK_DIV_RST     = 16'h3040;
   localparam logic [15:0] CLK_DIV_MASK    = 16'hffdf;
   localparam logic [8:0]  PLL_FBD_RST     = 9'h030;
   localparam logic [5:0]  FRC_TUNE_RST    = 6'h00;
   // Clock source codes
   localparam logic [2:0]  SRC_FRC         = 3'h0;
   localparam logic [2:0]  SRC_FRC_PLL     = 3'h1;
   localparam logic [2:0]  SRC_PRI         = 3'h2;
   localparam logic [2:0]  SRC_PRI_PLL     = 3'h3;
   localparam logic [2:0]  SRC_SEC         = 3'h4;
   localparam logic [2:0]  SRC_LOW_POWER_RC_SOURCE        = 3'h5;
   localparam logic [1:0]  POST_RESERVED   = 2'h2;
   localparam int          SETTLE_CYCLES   = 10;
   typedef enum logic [3:0] {
      SW_IDLE   = 4'b0001,
      SW_START  = 4'b0010,
      SW_SETTLE = 4'b0100,
      SW_DONE   = 4'b1000
   } sw_state_t;
endpackage

// ---- src/sync2.sv ----
// Two-flop synchroniser for levels arriving from outside the core clock
`timescale 1ns/10ps
`default_nettype none
module sync2 #(
   parameter int W = 1
) (
   input  wire logic         core_clk, // Core clock
   input  wire logic         rst_n,    // Synchronous reset, active low
   input  wire logic [W-1:0] d,        // Asynchronous input
   output logic      [W-1:0] q         // Synchronised output
);
   logic [W-1:0] meta_r;
   logic [W-1:0] meta_nxt;
   logic [W-1:0] q_nxt;

   always_comb begin
      meta_nxt = d;
      q_nxt    = meta_r;
   end

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= meta_nxt;
         q      <= q_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- src/settle_counter.sv ----
// Counts edges of the new clock, seen through its synchronised level, up to a settle figure
`timescale 1ns/10ps
`default_nettype none
module settle_counter #(
   parameter int COUNT = 10
) (
   input  wire logic core_clk, // Core clock
   input  wire logic rst_n,    // Synchronous reset, active low
   input  wire logic start,    // Restart the count
   input  wire logic clk_lvl,  // Synchronised level of the new clock
   output logic      done      // Settle count reached
);
   logic [7:0] cnt_r;
   logic [7:0] cnt_nxt;
   logic       lvl_r;
   logic       lvl_nxt;

   always_comb begin
      lvl_nxt = clk_lvl;
      cnt_nxt = cnt_r;
      if (start) begin
         cnt_nxt = 8'h00;
      end else if (clk_lvl && !lvl_r && cnt_r != 8'(COUNT)) begin
         cnt_nxt = cnt_r + 8'h01;
      end
   end

   assign done = (cnt_r == 8'(COUNT)) && !start;

   always_ff @(posedge core_clk) begin
      if (!rst_n) begin
         cnt_r <= 8'h00;
         lvl_r <= 1'b0;
      end else begin
         cnt_r <= cnt_nxt;
         lvl_r <= lvl_nxt;
      end
   end
endmodule
`default_nettype wire

// ---- tb/osc_ctrl_sva.sv ----
// Port-level assertions for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
module osc_ctrl_sva
   import osc_ctrl_pkg::*;
(
   input wire logic        core_clk,          // Core clock
   input wire logic        rst_n,             // Reset, active low
   input wire logic        por_n,             // Power-on reset, active low
   input wire logic [3:0]  reg_addr,          // Register index
   input wire logic [15:0] reg_wdata,         // Write data
   input wire logic        reg_wr,            // Write strobe
   input wire logic        reg_rd,            // Read strobe
   input wire logic [15:0] reg_rdata,         // Read data
   input wire logic        switch_enable,     // Switching enabled
   input wire logic        irq_any,           // Interrupt taken
   input wire logic        secondary_osc_run, // Secondary enable
   input wire logic        clock_fail_trap,   // Failure trap
   input wire logic [7:0]  doze_divide,       // Doze ratio
   input wire logic [8:0]  fast_rc_divide,    // Postscaler divide
   input wire logic [5:0]  pll_pre_divide,    // Prescaler divide
   input wire logic [9:0]  pll_multiplier,    // Feedback multiplier
   input wire logic [5:0]  tuning_steps       // Tuning steps
);
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rst_n || !por_n);
   // Read launched, data standing in the following cycle
   sequence s_rd(logic [3:0] idx);
      (reg_rd && reg_addr == idx) ##1 1'b1;
   endsequence
   // Two key writes, spaced as the bus tasks issue them
   sequence s_unlock;
      (reg_wr && reg_addr == OFS_UNLOCK && reg_wdata == UNLOCK_KEY1) ##2
      (reg_wr && reg_addr == OFS_UNLOCK && reg_wdata == UNLOCK_KEY2);
   endsequence
   a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
      else $error("read data not zero outside read cycle");
   a_mult_plus_two: assert property (s_rd(OFS_PLL_FBD) |->
      pll_multiplier == {1'b0, reg_rdata[8:0]} + 10'h002 && reg_rdata[15:9] == 7'h00)
      else $error("feedback multiplier mismatch");
   a_pre_plus_two: assert property (s_rd(OFS_CLK_DIV) |->
      pll_pre_divide == {1'b0, reg_rdata[4:0]} + 6'h02 && !reg_rdata[5])
      else $error("input prescaler mismatch");
   a_doze_ratio: assert property (s_rd(OFS_CLK_DIV) ##0 !$past(irq_any) |->
      doze_divide == (reg_rdata[REDUCTION_RATIO_ENABLE_BIT] ? 8'h01 << reg_rdata[14:12] : 8'h01))
      else $error("doze ratio mismatch");
   a_frc_postscale: assert property (s_rd(OFS_CLK_DIV) |->
      fast_rc_divide == (reg_rdata[10:8] == 3'h7 ? 9'h100 : 9'h001 << reg_rdata[10:8]))
      else $error("fast rc postscaler mismatch");
   a_tuning_field: assert property (s_rd(OFS_FRC_TUNE) |->
      tuning_steps == reg_rdata[5:0] && reg_rdata[15:6] == 10'h000)
      else $error("tuning field mismatch");
   a_ctrl_unimpl: assert property (s_rd(OFS_OSC_CTRL) |->
      !reg_rdata[2] && !reg_rdata[4] && !reg_rdata[11])
      else $error("unimplemented control bit set");
   a_swreq_held: assert property (s_rd(OFS_OSC_CTRL) ##0
      (!switch_enable && !$past(switch_enable, 3)) |-> !reg_rdata[SWREQ_BIT])
      else $error("switch request set while switching disabled");
   a_roi_clears: assert property (s_rd(OFS_CLK_DIV) ##0
      (reg_rdata[ROI_BIT] && irq_any && !reg_wr) |=> doze_divide == 8'h01)
      else $error("interrupt did not restore 1:1 ratio");
   a_trap_pulse: assert property (clock_fail_trap |=> !clock_fail_trap)
      else $error("trap longer than one cycle");
   a_unlock_write: assert property (s_unlock ##2
      (reg_wr && reg_addr == OFS_OSC_CTRL && reg_wdata[SEC_EN_BIT]) |-> ##[1:3] secondary_osc_run)
      else $error("unlocked write did not enable secondary oscillator");
endmodule
bind osc_clock_divider_pll_config osc_ctrl_sva u_osc_ctrl_sva (
   .core_clk, .rst_n, .por_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
   .switch_enable, .irq_any, .secondary_osc_run, .clock_fail_trap, .doze_divide,
   .fast_rc_divide, .pll_pre_divide, .pll_multiplier, .tuning_steps
);
`default_nettype wire

// ---- tb/osc_clock_divider_pll_config_tb_top.sv ----
// Self-checking testbench for the oscillator control block
`timescale 1ns/10ps
`default_nettype none
module osc_clock_divider_pll_config_tb_top;
   import osc_ctrl_pkg::*;
   logic        core_clk = 1'b0;
   logic        rst_n = 1'b0, por_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
   logic [3:0]  reg_addr = 4'h0;
   logic [15:0] reg_wdata = 16'h0000;
   logic        switch_enable = 1'b1, fail_detect = 1'b0, pll_locked = 1'b0;
   logic        new_clk_ready = 1'b0, new_clk_level = 1'b0, irq_any = 1'b0;
   logic [1:0]  primary_submode_config = 2'h2;
   logic [15:0] reg_rdata, d;
   logic [2:0]  current_source_status, request_source;
   logic        secondary_osc_run, clock_fail_trap;
   logic [1:0]  primary_submode;
   logic [7:0]  doze_divide;
   logic [8:0]  fast_rc_divide;
   logic [3:0]  pll_post_divide;
   logic [5:0]  pll_pre_divide, tuning_steps;
   logic [9:0]  pll_multiplier;
   int          mismatches = 0, comparisons = 0, cycles = 0;

   osc_clock_divider_pll_config u_osc_clock_divider_pll_config (
      .core_clk, .rst_n, .por_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .switch_enable, .boot_source(SRC_FRC), .primary_submode_config, .fail_detect,
      .pll_locked, .new_clk_ready, .new_clk_level, .irq_any, .current_source_status,
      .secondary_osc_run, .request_source, .clock_fail_trap, .primary_submode,
      .doze_divide, .fast_rc_divide, .pll_post_divide, .pll_pre_divide, .pll_multiplier,
      .tuning_steps
   );

   always #5 core_clk = ~core_clk;
   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 5000) begin
         mismatches++;
         final_report();
      end
   end

   task automatic final_report();
      $display("mismatches %0d comparisons %0d", mismatches, comparisons);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp) begin
         mismatches++;
         $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] v);
      @(posedge core_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= v;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask
   // Unlocked write to the oscillator control register
   task automatic cw(input logic [15:0] v);
      wr(OFS_UNLOCK, UNLOCK_KEY1);
      wr(OFS_UNLOCK, UNLOCK_KEY2);
      wr(OFS_OSC_CTRL, v);
   endtask

   task automatic t_reset_values();
      rd(OFS_OSC_CTRL);
      chk(d, 16'h0000);
      rd(OFS_CLK_DIV);
      chk(d, 16'h3040);
      rd(OFS_PLL_FBD);
      chk(d, 16'h0030);
      rd(OFS_FRC_TUNE);
      chk(d, 16'h0000);
      rd(4'h9);
      chk(d, 16'h0000);
      chk({6'h00, pll_multiplier}, 16'h0032);
      chk({12'h000, pll_post_divide}, 16'h0004);
      chk({10'h000, pll_pre_divide}, 16'h0002);
      chk({8'h00, doze_divide}, 16'h0001);
      chk({7'h00, fast_rc_divide}, 16'h0001);
      chk({14'h0000, primary_submode}, 16'h0002);
   endtask

   task automatic t_divisors();
      logic [15:0] v;
      logic [1:0]  p;
      for (int c = 0; c < 8; c++) begin
         v = {1'b0, 3'(c), 1'b1, 3'(c), 2'(c), 1'b0, 5'(c)};
         p = 2'(c);
         wr(OFS_CLK_DIV, v);
         rd(OFS_CLK_DIV);
         chk(d, v);
         chk({8'h00, doze_divide}, 16'h0001 << c);
         chk({7'h00, fast_rc_divide}, c == 7 ? 16'h0100 : 16'h0001 << c);
         chk({10'h000, pll_pre_divide}, 16'(c + 2));
         if (p != 2'h2) chk({12'h000, pll_post_divide}, p == 2'h3 ? 16'h0008 : 16'h0002 << p);
      end
      wr(OFS_CLK_DIV, 16'hffff);
      rd(OFS_CLK_DIV);
      chk(d, 16'hffdf);
      chk({10'h000, pll_pre_divide}, 16'h0021);
      wr(OFS_PLL_FBD, 16'hffff);
      rd(OFS_PLL_FBD);
      chk(d, 16'h01ff);
      chk({6'h00, pll_multiplier}, 16'h0201);
      wr(OFS_FRC_TUNE, 16'hffff);
      rd(OFS_FRC_TUNE);
      chk(d, 16'h003f);
      wr(OFS_FRC_TUNE, 16'h0020);
      rd(OFS_FRC_TUNE);
      chk({10'h000, tuning_steps}, 16'h0020);
   endtask

   task automatic t_roi();
      wr(OFS_CLK_DIV, 16'hb800);
      @(posedge core_clk);
      reg_rd <= 1'b1;
      reg_addr <= OFS_CLK_DIV;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      irq_any <= 1'b1;
      @(posedge core_clk);
      irq_any <= 1'b0;
      rd(OFS_CLK_DIV);
      chk(d, 16'hb000);
      chk({8'h00, doze_divide}, 16'h0001);
      wr(OFS_CLK_DIV, 16'h3800);
      @(posedge core_clk);
      irq_any <= 1'b1;
      @(posedge core_clk);
      irq_any <= 1'b0;
      rd(OFS_CLK_DIV);
      chk(d, 16'h3800);
      chk({8'h00, doze_divide}, 16'h0008);
   endtask

   task automatic t_por();
      wr(OFS_CLK_DIV, 16'h1111);
      primary_submode_config <= 2'h1;
      rst_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      rd(OFS_CLK_DIV);
      chk(d, 16'h1111);
      chk({14'h0000, primary_submode}, 16'h0002);
      rst_n <= 1'b0;
      por_n <= 1'b0;
      cyc(2);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      rd(OFS_CLK_DIV);
      chk(d, 16'h3040);
      chk({14'h0000, primary_submode}, 16'h0001);
   endtask

   task automatic t_lock();
      wr(OFS_OSC_CTRL, 16'h0002);
      wr(OFS_UNLOCK, UNLOCK_KEY1);
      wr(OFS_OSC_CTRL, 16'h0002);
      rd(OFS_OSC_CTRL);
      chk(d, 16'h0000);
      chk({15'h0000, secondary_osc_run}, 16'h0000);
      cw(16'h0002);
      rd(OFS_OSC_CTRL);
      chk(d, 16'h0002);
      chk({15'h0000, secondary_osc_run}, 16'h0001);
      wr(OFS_OSC_CTRL, 16'h0000);
      rd(OFS_OSC_CTRL);
      chk(d, 16'h0002);
   endtask

   task automatic t_switch();
      new_clk_ready <= 1'b1;
      // Plain source to secondary: FRC to SRC_SEC, no PLL lock wait
      cw(16'h0403);
      rd(OFS_OSC_CTRL);
      chk(d, 16'h0403);
      chk({13'h0000, request_source}, 16'h0004);
      repeat (9) begin
         new_clk_level <= 1'b1;
         cyc(3);
         new_clk_level <= 1'b0;
         cyc(3);
      end
      cyc(6);
      rd(OFS_OSC_CTRL);
      chk(d, 16'h0403);
      new_clk_level <= 1'b1;
      cyc(12);
      new_clk_level <= 1'b0;
      rd(OFS_OSC_CTRL);
      chk(d, 16'h4402);
      chk({13'h0000, current_source_status}, 16'h0004);
      cw(16'h0403);
      rd(OFS_OSC_CTRL);
      chk(d, 16'h4402);
   endtask

   task automatic t_fail();
      logic seen;
      seen = 1'b0;
      fail_detect <= 1'b1;
      for (int i = 0; i < 10 && !seen; i++) begin
         @(posedge core_clk);
         seen = clock_fail_trap;
      end
      chk({15'h0000, seen}, 16'h0001);
      fail_detect <= 1'b0;
      cyc(4);
      rd(OFS_OSC_CTRL);
      chk({12'h000, d[14:12], d[3]}, 16'h0001);
      cw(16'h000a);
      rd(OFS_OSC_CTRL);
      chk({15'h0000, d[3]}, 16'h0001);
      cw(16'h0002);
      rd(OFS_OSC_CTRL);
      chk({15'h0000, d[3]}, 16'h0000);
      cw(16'h000a);
      rd(OFS_OSC_CTRL);
      chk({15'h0000, d[3]}, 16'h0000);
   endtask

   task automatic t_disabled();
      switch_enable <= 1'b0;
      cw(16'h0403);
      rd(OFS_OSC_CTRL);
      chk({15'h0000, d[0]}, 16'h0000);
      chk({13'h0000, current_source_status}, 16'h0000);
      switch_enable <= 1'b1;
   endtask

   initial begin
      cyc(10);
      rst_n <= 1'b1;
      por_n <= 1'b1;
      cyc(1);
      t_reset_values();
      t_divisors();
      t_roi();
      t_por();
      t_lock();
      t_switch();
      t_fail();
      t_disabled();
      final_report();
   end
endmodule
`default_nettype wire
